// ### hw/dram_seq.sv
// page-mode dram access sequencer with request fifo and refresh timer
`timescale 1ns/1ps
`default_nettype none
`include "dram_seq_map.svh"
module dram_seq #(
  parameter int CLOCK_MHZ = 40,
  parameter int REF_PERIOD_CYC =
    (`REF_INTERVAL_US * CLOCK_MHZ) / `REF_ROWS,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic memory_system_on,
  input wire logic decode_sequence_enable,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [9:0] req_row,
  input wire logic [9:0] req_col,
  input wire logic [3:0] req_wdata,
  output logic rd_valid,
  output logic [3:0] rd_data,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [9:0] mux_address_lines,
  output logic [3:0] memory_data_lines_o,
  output logic memory_data_lines_oe,
  input wire logic [3:0] memory_data_lines_i
);
  localparam int RW = 12;
  localparam int FW = 25;
  logic [FW-1:0] f_data;
  logic f_valid;
  logic f_pop;
  logic fifo_ready;
  dram_seq_pkg::seq_state_t st_q;
  dram_seq_pkg::op_t op_q;
  logic [3:0] cnt_q;
  logic [9:0] col_q;
  logic [RW-1:0] ref_cnt_q;
  logic ref_pend_q;
  logic [9:0] ref_row_q;
  logic [3:0] din_s1_q;
  logic [3:0] din_s2_q;
  logic req_ready_q;

  ////////////////////////////////////////////////////////////////////
  dram_seq_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(req_valid && req_ready_q),
    .in_ready(fifo_ready),
    .in_data({req_write, req_row, req_col, req_wdata}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ready drops for a cycle after each take so that the registered
  // copy never promises a slot that the last push has just filled
  always_ff @(posedge clock) begin
    if (srst) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= fifo_ready && !(req_valid && req_ready_q);
    end
  end
  assign req_ready = req_ready_q;

  ////////////////////////////////////////////////////////////////////
  // refresh only while the memory system decodes; one row per period
  always_ff @(posedge clock) begin
    if (srst) begin
      ref_cnt_q <= '0;
      ref_pend_q <= 1'b0;
    end else if (!(memory_system_on && decode_sequence_enable)) begin
      ref_cnt_q <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_cnt_q == RW'(REF_PERIOD_CYC - 1)) begin
        ref_cnt_q <= '0;
      end else begin
        ref_cnt_q <= ref_cnt_q + 1'b1;
      end
      // pending set wins over the clear on start
      if (ref_cnt_q == RW'(REF_PERIOD_CYC - 1)) begin
        ref_pend_q <= 1'b1;
      end else if (st_q == dram_seq_pkg::st_idle) begin
        ref_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data pins are off-domain: two stages before use; the first stage
  // takes the pin on the very edge on which cas rises
  always_ff @(posedge clock) begin
    din_s1_q <= memory_data_lines_i;
    din_s2_q <= din_s1_q;
  end

  // fifo pop only when idle and no refresh outranks it
  assign f_pop = (st_q == dram_seq_pkg::st_idle) && !ref_pend_q
    && f_valid && memory_system_on;

  // refresh cycles are ras-only and never touch the column side
  // or the data pins
  function automatic logic uses_column(input dram_seq_pkg::op_t op);
    return op != dram_seq_pkg::op_refresh;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // access sequence: setup, ras low, cas low, precharge
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= dram_seq_pkg::st_idle;
      op_q <= dram_seq_pkg::op_read;
      cnt_q <= '0;
      col_q <= '0;
      ref_row_q <= '0;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mux_address_lines <= '0;
      memory_data_lines_o <= '0;
      memory_data_lines_oe <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      unique case (st_q)
        dram_seq_pkg::st_idle: begin
          cnt_q <= '0;
          // refresh outranks queued requests
          if (ref_pend_q) begin
            op_q <= dram_seq_pkg::op_refresh;
            mux_address_lines <= ref_row_q;
            ref_row_q <= ref_row_q + 1'b1;
            st_q <= dram_seq_pkg::st_row;
          end else if (f_pop) begin
            op_q <= f_data[24] ? dram_seq_pkg::op_write
                               : dram_seq_pkg::op_read;
            mux_address_lines <= f_data[23:14];
            col_q <= f_data[13:4];
            st_q <= dram_seq_pkg::st_row;
            // setup plus ras-to-cas is just three, so the write lead of
            // three has to start here, before ras falls
            if (f_data[24]) begin
              write_strobe_n <= 1'b0;
              memory_data_lines_o <= f_data[3:0];
              memory_data_lines_oe <= 1'b1;
            end else begin
              output_enable_n <= 1'b0;
            end
          end
        end
        dram_seq_pkg::st_row: begin
          // one cycle of row address setup ends here
          if (cnt_q == `ADS_CYC - 4'h1) begin
            row_strobe_n <= 1'b0;
            cnt_q <= '0;
            st_q <= dram_seq_pkg::st_cas;
          end
        end
        dram_seq_pkg::st_cas: begin
          // ras fell at count 0; address held one cycle then column
          if (cnt_q == `ADS_CYC - 4'h1 && uses_column(op_q)) begin
            mux_address_lines <= col_q;
          end
          // cas falls two after ras with the column set one before
          if (cnt_q == `RCD_CYC - 4'h1 && uses_column(op_q)) begin
            column_strobe_n <= 1'b0;
          end
          // read data is taken on this edge, before cas rises
          if (cnt_q == `RCD_CYC + `CAS_LOW_CYC - 4'h1) begin
            column_strobe_n <= 1'b1;
          end
          if (cnt_q == `RCD_CYC + `WDH_CYC - 4'h1) begin
            memory_data_lines_oe <= 1'b0;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
          end
          // ras and cas rise together; precharge counts from here
          if (cnt_q == `RAS_LOW_CYC - 4'h1) begin
            row_strobe_n <= 1'b1;
            cnt_q <= '0;
            st_q <= dram_seq_pkg::st_pre;
          end
        end
        dram_seq_pkg::st_pre: begin
          // ras stays high for its minimum before the next access
          if (cnt_q == `RAS_HIGH_CYC - 4'h1) begin
            st_q <= dram_seq_pkg::st_idle;
          end
        end
        default: begin
          st_q <= dram_seq_pkg::st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // the pin value seen at the cas-rise edge leaves the synchroniser
  // two edges later, early in precharge; that latency is the price
  // of the two stages on the off-domain data pins
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (st_q == dram_seq_pkg::st_pre && op_q == dram_seq_pkg::op_read
          && cnt_q == `RD_SYNC_CYC - 4'h1) begin
        rd_data <= din_s2_q;
        rd_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/dram_seq_map.svh
// timing constants and refresh interval and row count for the dram access sequencer
// Operation
// - column strobe falls two cycles after row
// - write strobe falls three cycles before column
// - row address one cycle before, held one after
// - write data three before, three after column fall
// - read data captured at column strobe rise
`ifndef DRAM_SEQ_MAP_SVH
`define DRAM_SEQ_MAP_SVH
`define RAS_LOW_CYC 4'h5
`define RAS_HIGH_CYC 4'h3
`define RCD_CYC 4'h2
`define CAS_LOW_CYC 4'h3
`define WCS_CYC 4'h3
`define WDH_CYC 4'h3
`define RD_SYNC_CYC 4'h2
`define ADS_CYC 4'h1
`define REF_INTERVAL_US 1400
`define REF_ROWS 1024
`endif

// ### hw/dram_seq_pkg.sv
// types for the dram access sequencer
package dram_seq_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_row,
    st_cas,
    st_pre
  } seq_state_t;
  typedef enum logic [1:0] {
    op_read,
    op_write,
    op_refresh
  } op_t;
endpackage

// ### hw/dram_seq_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dram_seq_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != DEPTH[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// ### testbench/dram_model.sv
// behavioural page-mode dram on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
  parameter int DLY_NS = 20
) (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [9:0] mux_address_lines,
  input wire logic [3:0] memory_data_lines_o,
  output logic [3:0] dq,
  output logic dq_en
);
  logic [3:0] mem [int];
  logic [9:0] row_q;
  logic [3:0] rd_q = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic ok_q = 1'b0;
  int k;
  always @(negedge row_strobe_n) row_q = mux_address_lines;
  always @(negedge column_strobe_n) begin
    k = int'({row_q, mux_address_lines});
    if (!write_strobe_n) begin
      mem[k] = memory_data_lines_o;
      last_q = memory_data_lines_o;
    end else begin
      rd_q = mem.exists(k) ? mem[k] : 4'h0;
      ok_q <= #(DLY_NS) 1'b1;
    end
  end
  always @(posedge column_strobe_n) begin
    ok_q = 1'b0;
    last_q = rd_q;
  end
  // until the access delay runs out the lines show junk, not old data
  assign dq_en = !column_strobe_n && !output_enable_n;
  assign dq = (dq_en && ok_q) ? rd_q : ~last_q;
endmodule
`default_nettype wire

// ### testbench/dram_seq_assertions.sv
// timing assertions for the dram access sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_seq_checker #(
  parameter int REF_PERIOD_CYC = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic memory_system_on,
  input wire logic decode_sequence_enable,
  input wire logic rd_valid,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [9:0] mux_address_lines,
  input wire logic [3:0] memory_data_lines_o,
  input wire logic memory_data_lines_oe
);
  int gap_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // slack of 12 covers one access already under way
  always_ff @(posedge clock) begin
    if (srst || !row_strobe_n || !memory_system_on || !decode_sequence_enable)
      gap_q <= 0;
    else
      gap_q <= gap_q + 1;
  end
  AST_RCD:
  assert property ($fell(column_strobe_n) |->
    !$past(row_strobe_n, 2) && $past(row_strobe_n, 3)) else $error("rcd");
  AST_WCS:
  assert property ($fell(write_strobe_n) |-> ##3 $fell(column_strobe_n))
    else $error("wcs");
  AST_ROW_ADDR:
  assert property ($fell(row_strobe_n) |-> $stable(mux_address_lines))
    else $error("row address");
  AST_WDATA:
  assert property ($fell(column_strobe_n) && memory_data_lines_oe |->
    $past(memory_data_lines_oe, 3) &&
    $past(memory_data_lines_o, 3) == memory_data_lines_o ##0
    (memory_data_lines_oe && $stable(memory_data_lines_o))[*3])
    else $error("write data");
  AST_RD_RISE:
  assert property (rd_valid |-> $past(column_strobe_n, 2) &&
    !$past(column_strobe_n, 3) && !$past(output_enable_n, 3))
    else $error("read capture");
  AST_REFRESH:
  assert property (gap_q <= REF_PERIOD_CYC + 12) else $error("refresh");
endmodule
bind dram_seq dram_seq_checker #(.REF_PERIOD_CYC(REF_PERIOD_CYC))
  dram_seq_checker_i (.clock, .srst, .memory_system_on,
  .decode_sequence_enable, .rd_valid, .row_strobe_n, .column_strobe_n,
  .output_enable_n, .write_strobe_n, .mux_address_lines,
  .memory_data_lines_o, .memory_data_lines_oe);
`default_nettype wire

// ### testbench/dram_seq_tb.sv
// self-checking bench for the dram access sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_seq_tb;
  typedef struct packed {
    logic wr;
    logic [9:0] row;
    logic [9:0] col;
    logic [3:0] dat;
  } case_t;
  logic clock, srst, memory_system_on, decode_sequence_enable, req_valid;
  logic req_write, req_ready, rd_valid, row_strobe_n, column_strobe_n;
  logic output_enable_n, write_strobe_n, memory_data_lines_oe, dq_en, p;
  logic [9:0] req_row, req_col, mux_address_lines;
  logic [3:0] req_wdata, rd_data, memory_data_lines_o;
  logic [3:0] memory_data_lines_i, dq;
  int failures = 0, tests_run = 0, cyc = 0, n;
  // reads carry the value that they should return
  case_t cases [8] = '{'{1, 10'h3ff, 10'h000, 4'ha},
    '{1, 10'h000, 10'h3ff, 4'h5}, '{1, 10'h155, 10'h2aa, 4'hf},
    '{0, 10'h3ff, 10'h000, 4'ha}, '{0, 10'h000, 10'h3ff, 4'h5},
    '{0, 10'h155, 10'h2aa, 4'hf}, '{1, 10'h3ff, 10'h000, 4'h0},
    '{0, 10'h3ff, 10'h000, 4'h0}};
  dram_seq #(.REF_PERIOD_CYC(24)) dram_seq_i (.clock, .srst,
    .memory_system_on, .decode_sequence_enable, .req_valid, .req_ready,
    .req_write, .req_row, .req_col, .req_wdata, .rd_valid, .rd_data,
    .row_strobe_n, .column_strobe_n, .output_enable_n, .write_strobe_n,
    .mux_address_lines, .memory_data_lines_o, .memory_data_lines_oe,
    .memory_data_lines_i);
  dram_model #(.DLY_NS(20)) dram_model_i (.row_strobe_n, .column_strobe_n,
    .output_enable_n, .write_strobe_n, .mux_address_lines,
    .memory_data_lines_o, .dq, .dq_en);
  // both driving at once shows as unknown
  assign memory_data_lines_i = memory_data_lines_oe ?
    (dq_en ? 4'hx : memory_data_lines_o) : dq;
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk1(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t read %h not %h", $time, got, exp);
    end
  endtask
  // leaves the request raised so back-to-back sends keep it up
  task automatic send(input case_t c);
    {req_write, req_row, req_col, req_wdata} <= c;
    req_valid <= 1'b1;
    n = 0;
    do @(negedge clock); while (!req_ready && ++n < 40);
    chk1(req_ready, "request not taken");
    @(posedge clock);
  endtask
  task automatic wait_rd(input logic [3:0] exp);
    n = 0;
    do @(negedge clock); while (!rd_valid && ++n < 1000);
    chk1(rd_valid, "no read result");
    chk4(rd_data, exp);
    @(posedge clock);
  endtask
  initial begin
    {srst, memory_system_on, decode_sequence_enable} <= 3'h7;
    {req_valid, req_write, req_row, req_col, req_wdata} <= '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk1(row_strobe_n & column_strobe_n & write_strobe_n & output_enable_n
      & !memory_data_lines_oe & (mux_address_lines === 10'h000), "reset");
    @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    foreach (cases[i]) begin
      send(cases[i]);
      req_valid <= 1'b0;
      if (cases[i].wr) repeat (16) @(posedge clock);
      else wait_rd(cases[i].dat);
    end
    n = 0;
    repeat (60) begin
      p = row_strobe_n;
      @(negedge clock);
      if (p && !row_strobe_n) n++;
    end
    chk1(n >= 2, "refresh too rare");
    @(posedge clock);
    {memory_system_on, decode_sequence_enable} <= 2'h0;
    for (int k = 0; k < 16; k++) send({1'b1, 10'(k), 10'h100, 4'(k)});
    // a stray write of zero over row 15 would spoil the last read
    {req_write, req_row, req_wdata} <= {1'b1, 10'h00f, 4'h0};
    repeat (4) @(negedge clock);
    chk1(!req_ready, "full fifo took a request");
    @(posedge clock);
    {memory_system_on, decode_sequence_enable} <= 2'h3;
    send({1'b0, 10'h00f, 10'h100, 4'h0});
    req_valid <= 1'b0;
    wait_rd(4'hf);
    give_verdict();
  end
endmodule
`default_nettype wire
